/* hdl/pll_mode_control.sv */
// Purpose: Free run, genlock and holdover mode control of the VCXO loop
// Assumes: Analog switch and filter driver sit outside; sync pins async
// Notes: Reference loss is judged from the time between hsync edges
//
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
// What this block and its host do
// R1 - Lock enable 0 gives free run; VCXO independent of reference.
// R2 - Lock enable 1 gives genlock to selected port's horizontal sync.
// R3 - Source select 0 takes the mode from the lock mode pin.
// R4 - Free run closes switch joining bias input to loop filter output.
// R5 - Genlock, hold bit 0: reference loss falls back to free run.
// R6 - Genlock, hold bit 1: reference loss enters holdover.
// R7 - Returning reference immediately resumes locking attempts.
// R8 - Free run mode never tries to lock, reference or not.
// R9 - Holdover tri-states loop filter output as loss flag rises.
// R10 - Genlock locks to whatever sync arrives, with no qualification.
// R11 - Alignment enable re-aligns outputs on every output frame; here it pulses only on reference vsync edges while genlocked.
// R12 - Host clears alignment enable right after output initialisation.
// R13 - Host programs clocks, frame timing, dividers, lock, then init.
// R14 - Host programs frame timing before genlock even if unused.
// R15 - Power-on reset returns every control register to default.
// R16 - Loss and lock-missing flags follow current operating state.
// R17 - Sync error tolerance sets the reference loss threshold.
// R18 - After reset the block starts in free run.
// R19 - Genlock request is register bit or inverted active-low pin.
module pll_mode_control #(
    parameter int LOSS_CYC = pll_mode_pkg::LOSS_BASE_CYC
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic lockModeN,
    input wire logic hsyncIn,
    input wire logic vsyncIn,
    input wire logic pllLocked,
    output logic freerunSwitchClose,
    output logic loopFilterOe,
    output logic pdEnable,
    output logic refLoss,
    output logic lockMissing,
    output logic frameAlignPulse,
    output logic irq
);
    localparam int CW = 32;

    localparam int NPIN = 4;
    logic lockModeReq;
    logic hsyncLevel;
    logic hsyncRise;
    logic vsyncRise;
    logic pllLockedSync;
    logic [NPIN-1:0] pinRaw;
    logic [NPIN-1:0] pinLevel;
    logic [NPIN-1:0] pinRise;

    // The mode pin is inverted ahead of its synchroniser: the request
    // then idles low like the flops after reset, so a reset never
    // shows a false genlock request
    assign pinRaw = {pllLocked, vsyncIn, hsyncIn, ~lockModeN};

    // One synchroniser per asynchronous pin
    for (genvar p = 0; p < NPIN; p++) begin : g_pin
        sync_input u_sync_input (
            .core_clk(core_clk),
            .nrst(nrst),
            .pin(pinRaw[p]),
            .level(pinLevel[p]),
            .rise(pinRise[p])
        );
    end

    // Only the sync edges act as events; mode and lock are levels
    assign lockModeReq = pinLevel[0];
    assign hsyncLevel = pinLevel[1];
    assign hsyncRise = pinRise[1];
    assign vsyncRise = pinRise[2];
    assign pllLockedSync = pinLevel[3];

    // Register state
    logic [31:0] ctrl;
    logic [pll_mode_pkg::IRQ_W-1:0] irqStatus;
    logic [pll_mode_pkg::IRQ_W-1:0] irqMask;
    logic [CW-1:0] hsPeriod;
    logic [31:0] next_ctrl;
    logic [pll_mode_pkg::IRQ_W-1:0] next_irqStatus;
    logic [pll_mode_pkg::IRQ_W-1:0] next_irqMask;
    logic [31:0] next_wb_dat_o;
    logic next_wb_ack_o;

    // Mode and loss state
    pll_mode_pkg::op_state_t opState;
    pll_mode_pkg::op_state_t next_opState;
    logic [CW-1:0] gapCount;
    logic [CW-1:0] next_gapCount;
    logic [CW-1:0] next_hsPeriod;
    logic next_refLoss;
    logic lockMissingPrev;
    logic genlockReq;
    logic [CW-1:0] lossLimit;
    logic [3:0] events;
    logic [31:0] statusWord;
    logic wbReq;

    assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    // Effective mode request from register or pin
    // The pin request is already active high after its synchroniser
    always_comb begin
        if (ctrl[pll_mode_pkg::CTRL_SRC_BIT]) begin
            genlockReq = ctrl[pll_mode_pkg::CTRL_LOCK_BIT]; // [R19]
        end else begin
            genlockReq = lockModeReq; // [R3] [R19]
        end
    end

    // Tolerance widens the loss window by powers of two
    // A wider window rides out sync errors but reports loss later
    always_comb begin
        lossLimit = CW'(LOSS_CYC) << ctrl[pll_mode_pkg::CTRL_HERR_LSB +:
            pll_mode_pkg::HERR_W]; // [R17]
    end

    // Gap counter measures time since last hsync edge
    // It saturates rather than wraps, so a long gap never looks short
    always_comb begin
        next_gapCount = gapCount;
        next_hsPeriod = hsPeriod;
        next_refLoss = refLoss;
        if (hsyncRise) begin
            next_hsPeriod = gapCount;
            next_gapCount = '0;
            next_refLoss = 1'b0; // [R7]
        end else begin
            if (gapCount != {CW{1'b1}}) begin
                next_gapCount = gapCount + CW'(1);
            end
            if (gapCount >= lossLimit) begin
                next_refLoss = 1'b1; // [R17]
            end
        end
    end

    // Operating state; loss and return act in the same cycle as the flag
    always_comb begin
        next_opState = opState;
        case (opState)
            pll_mode_pkg::FREERUN: begin
                if (genlockReq && !next_refLoss) begin
                    next_opState = pll_mode_pkg::GENLOCK; // [R2] [R7] [R10]
                end
            end
            pll_mode_pkg::GENLOCK: begin
                if (!genlockReq) begin
                    next_opState = pll_mode_pkg::FREERUN; // [R1]
                end else if (next_refLoss) begin
                    if (ctrl[pll_mode_pkg::CTRL_HOLD_BIT]) begin
                        next_opState = pll_mode_pkg::HOLDOVER; // [R6]
                    end else begin
                        next_opState = pll_mode_pkg::FREERUN; // [R5]
                    end
                end
            end
            pll_mode_pkg::HOLDOVER: begin
                if (!genlockReq) begin
                    next_opState = pll_mode_pkg::FREERUN; // [R1]
                end else if (!next_refLoss) begin
                    next_opState = pll_mode_pkg::GENLOCK; // [R7]
                end
            end
            default: begin
                next_opState = pll_mode_pkg::FREERUN;
            end
        endcase
    end

    // State, gap counter and loss flag; loss starts set so that a fresh
    // reset never claims a reference before the first sync edge
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            opState <= pll_mode_pkg::FREERUN; // [R18]
            gapCount <= '0;
            hsPeriod <= '0;
            refLoss <= 1'b1;
        end else begin
            opState <= next_opState;
            gapCount <= next_gapCount;
            hsPeriod <= next_hsPeriod;
            refLoss <= next_refLoss;
        end
    end

    // Analog controls decoded straight from state
    always_comb begin
        freerunSwitchClose = (opState == pll_mode_pkg::FREERUN); // [R4] [R5]
        // Holdover floats the filter in the cycle the loss flag rises
        loopFilterOe = (opState == pll_mode_pkg::GENLOCK); // [R9]
        pdEnable = (opState == pll_mode_pkg::GENLOCK); // [R8] [R10]
        // Lock missing unless genlocked and the loop reports lock
        lockMissing = ~((opState == pll_mode_pkg::GENLOCK) // [R16]
            & pllLockedSync);
    end

    // Re-align on each reference frame while enabled and genlocked, not just once
    assign frameAlignPulse = ctrl[pll_mode_pkg::CTRL_ALIGN_BIT] // [R11]
        & vsyncRise & hsyncLevel & (opState == pll_mode_pkg::GENLOCK);

    // Events: loss, regain, loss of lock
    always_comb begin
        events = 4'h0;
        events[pll_mode_pkg::IRQ_LOSS_BIT] = next_refLoss & ~refLoss;
        events[pll_mode_pkg::IRQ_REGAIN_BIT] = refLoss & ~next_refLoss;
        events[pll_mode_pkg::IRQ_LOCKLOST_BIT] = lockMissing
            & ~lockMissingPrev;
    end

    // Status word as software reads it
    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[pll_mode_pkg::STAT_MODE_LSB +: 2] = opState;
        statusWord[pll_mode_pkg::STAT_REFLOSS_BIT] = refLoss; // [R16]
        statusWord[pll_mode_pkg::STAT_LOCKLOSS_BIT] = lockMissing; // [R16]
    end

    // Bus slave: one-cycle ack, unmapped reads zero, writes ignored
    always_comb begin
        next_ctrl = ctrl;
        next_irqMask = irqMask;
        next_irqStatus = irqStatus;
        next_wb_ack_o = wbReq;
        next_wb_dat_o = 32'h0000_0000;
        if (wbReq && wb_we_i) begin
            case (wb_adr_i)
                pll_mode_pkg::CTRL_OFFSET: begin
                    for (int b = 0; b < 4; b++) begin
                        if (wb_sel_i[b]) begin
                            next_ctrl[8*b +: 8] = wb_dat_i[8*b +: 8];
                        end
                    end
                end
                pll_mode_pkg::IRQ_STATUS_OFFSET: begin
                    if (wb_sel_i[0]) begin
                        next_irqStatus = irqStatus
                            & ~wb_dat_i[pll_mode_pkg::IRQ_W-1:0];
                    end
                end
                pll_mode_pkg::IRQ_MASK_OFFSET: begin
                    if (wb_sel_i[0]) begin
                        next_irqMask = wb_dat_i[pll_mode_pkg::IRQ_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end else if (wbReq) begin
            case (wb_adr_i)
                pll_mode_pkg::CTRL_OFFSET: next_wb_dat_o = ctrl;
                pll_mode_pkg::STATUS_OFFSET: next_wb_dat_o = statusWord;
                pll_mode_pkg::IRQ_STATUS_OFFSET: begin
                    next_wb_dat_o = {29'h0, irqStatus};
                end
                pll_mode_pkg::IRQ_MASK_OFFSET: begin
                    next_wb_dat_o = {29'h0, irqMask};
                end
                pll_mode_pkg::HSYNC_PERIOD_OFFSET: next_wb_dat_o = hsPeriod;
                default: next_wb_dat_o = 32'h0000_0000;
            endcase
        end
        // Set wins over a same-cycle clear
        next_irqStatus = next_irqStatus | events[pll_mode_pkg::IRQ_W-1:0];
    end

    // Bus and interrupt registers; ack is registered, so every access
    // answers exactly one cycle after it is taken
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl <= pll_mode_pkg::CTRL_RESET; // [R15] [R18]
            irqStatus <= '0;
            irqMask <= '0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            lockMissingPrev <= 1'b1;
        end else begin
            ctrl <= next_ctrl;
            irqStatus <= next_irqStatus;
            irqMask <= next_irqMask;
            wb_ack_o <= next_wb_ack_o;
            wb_dat_o <= next_wb_dat_o;
            lockMissingPrev <= lockMissing;
        end
    end

    // Level interrupt: any set status bit that is unmasked
    assign irq = |(irqStatus & irqMask);
endmodule : pll_mode_control
`default_nettype wire

/* hdl/pll_mode_pkg.sv */
// Purpose: Shared constants for the genlock mode controller
// Assumes: 32-bit classic Wishbone register bus, 125 MHz core clock
// Notes: Offsets are byte addresses of aligned words
package pll_mode_pkg;
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFFSET = 8'h0C;
    localparam logic [7:0] HSYNC_PERIOD_OFFSET = 8'h10;
    // Control fields
    localparam int CTRL_LOCK_BIT = 0;
    localparam int CTRL_SRC_BIT = 1;
    localparam int CTRL_HOLD_BIT = 2;
    localparam int CTRL_ALIGN_BIT = 3;
    localparam int CTRL_HERR_LSB = 4;
    localparam int HERR_W = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // Interrupt event bits
    localparam int IRQ_LOSS_BIT = 0;
    localparam int IRQ_REGAIN_BIT = 1;
    localparam int IRQ_LOCKLOST_BIT = 2;
    localparam int IRQ_W = 3;
    // Status fields
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_REFLOSS_BIT = 2;
    localparam int STAT_LOCKLOSS_BIT = 3;
    // Timing: reference is lost when no sync edge for base window
    localparam int CLK_MHZ = 125;
    localparam int LOSS_BASE_US = 100;
    localparam int LOSS_BASE_CYC = LOSS_BASE_US * CLK_MHZ;
    localparam logic [31:0] PERIOD_RESET = 32'h0000_0000;
    typedef enum logic [1:0] {FREERUN, GENLOCK, HOLDOVER} op_state_t;
endpackage : pll_mode_pkg

/* hdl/sync_input.sv */
// Purpose: Three-flop synchroniser with agreement filter for a pin input
// Assumes: Input is asynchronous to core_clk
// Notes: Output changes once the second and third stages agree
`timescale 1ns/10ps
`default_nettype none
module sync_input (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic pin,
    output logic level,
    output logic rise
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic next_level;

    // Shift chain; stage[0] feeds only stage[1]
    always_comb begin
        next_stage = {stage[1:0], pin};
        next_level = (stage[1] == stage[2]) ? stage[2] : level;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            stage <= 3'h0;
            level <= 1'b0;
        end else begin
            stage <= next_stage;
            level <= next_level;
        end
    end

    assign rise = next_level & ~level;
endmodule : sync_input
`default_nettype wire

/* verification/pll_mode_control_tb.sv */
// Purpose: Self-checking bench for the genlock mode controller
// Assumes: Loss window shortened to 50 cycles
// Notes: Seeded random sync periods and pin noise
`timescale 1ns/10ps
`default_nettype none
module pll_mode_control_tb;
    localparam pll_mode_pkg::op_state_t FR = pll_mode_pkg::FREERUN;
    localparam pll_mode_pkg::op_state_t GL = pll_mode_pkg::GENLOCK;
    localparam pll_mode_pkg::op_state_t HO = pll_mode_pkg::HOLDOVER;
    logic core_clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00, period = 8'h14;
    logic [31:0] dat = 32'h0000_0000, rdat, rd;
    logic wb_ack_o, lockModeN = 1'b1, run = 1'b0, hsyncIn, vsyncIn;
    logic pllLocked, freerunSwitchClose, loopFilterOe, pdEnable, refLoss;
    logic lockMissing, frameAlignPulse, irq;
    int seed = 45, n_errors = 0, compares = 0, cycles = 0, pulses = 0;
    always #4 core_clk = ~core_clk;
    sync_source u_sync_source (.core_clk, .run, .period, .hsyncIn,
        .vsyncIn, .pllLocked);
    pll_mode_control #(.LOSS_CYC(50)) u_pll_mode_control (.core_clk,
        .nrst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o, .lockModeN, .hsyncIn, .vsyncIn, .pllLocked,
        .freerunSwitchClose, .loopFilterOe, .pdEnable, .refLoss,
        .lockMissing, .frameAlignPulse, .irq);
    // Ceiling on the whole run cuts any hang short
    always @(posedge core_clk) begin
        cycles++;
        if (frameAlignPulse === 1'b1) pulses++;
        if (cycles == 30000) begin
            n_errors++;
            results();
        end
    end
    function automatic logic [31:0] status(pll_mode_pkg::op_state_t s,
        logic loss, logic miss);
        return {28'h000_0000, miss, loss, s};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Classic cycle: hold the request until an edge samples ack high
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 100);
        // Read data is taken at the edge that sees ack, then release
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            n_errors++;
            $display("wrong value at %0t: no bus ack", $time);
        end
    endtask
    // Mode changes take a few cycles, so poll under a bound
    task automatic expect_status(input logic [31:0] exp);
        int n;
        n = 0;
        do begin
            wb(1'b0, pll_mode_pkg::STATUS_OFFSET, 32'h0000_0000);
            n++;
        end while (rd !== exp && n < 100);
        check(rd, exp);
    endtask
    task automatic irq_is(input logic exp);
        repeat (3) @(negedge core_clk);
        check({31'h0000_0000, irq}, {31'h0000_0000, exp});
    endtask
    task automatic results;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        wb(1'b0, pll_mode_pkg::CTRL_OFFSET, 32'h0000_0000);
        check(rd, pll_mode_pkg::CTRL_RESET);
        expect_status(status(FR, 1'b1, 1'b1));
        wb(1'b0, 8'h20, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        run <= 1'b1;
        expect_status(status(FR, 1'b0, 1'b1));
        lockModeN <= 1'b0;
        expect_status(status(GL, 1'b0, 1'b0));
        lockModeN <= 1'b1;
        expect_status(status(FR, 1'b0, 1'b1));
        $display("pin mode test done");
        for (int h = 0; h < 2; h++) begin
            period <= 8'(10 + $unsigned($random(seed)) % 16);
            lockModeN <= 1'($random(seed));
            wb(1'b1, 8'h00, 32'h0000_0003 | 32'(h << 2));
            expect_status(status(GL, 1'b0, 1'b0));
            run <= 1'b0;
            expect_status(status(h ? HO : FR, 1'b1, 1'b1));
            check({freerunSwitchClose, loopFilterOe}, {h == 0, 1'b0});
            run <= 1'b1;
            expect_status(status(GL, 1'b0, 1'b0));
        end
        $display("loss test done");
        period <= 8'h14;
        wb(1'b1, 8'h00, 32'h0000_0013);
        run <= 1'b0;
        repeat (60) @(posedge core_clk);
        wb(1'b0, pll_mode_pkg::STATUS_OFFSET, 32'h0000_0000);
        check(rd, status(GL, 1'b0, 1'b1));
        expect_status(status(FR, 1'b1, 1'b1));
        run <= 1'b1;
        wb(1'b1, 8'h00, 32'h0000_000B);
        expect_status(status(GL, 1'b0, 1'b0));
        pulses = 0;
        repeat (1100) @(posedge core_clk);
        check(32'(pulses >= 3), 32'h0000_0001);
        wb(1'b0, pll_mode_pkg::HSYNC_PERIOD_OFFSET, 32'h0000_0000);
        check(rd, 32'(period));
        wb(1'b1, 8'h00, 32'h0000_0003);
        pulses = 0;
        repeat (1100) @(posedge core_clk);
        check(32'(pulses), 32'h0000_0000);
        $display("alignment test done");
        wb(1'b1, pll_mode_pkg::IRQ_MASK_OFFSET, 32'h0000_0007);
        irq_is(1'b1);
        wb(1'b1, pll_mode_pkg::IRQ_STATUS_OFFSET, 32'h0000_0007);
        irq_is(1'b0);
        run <= 1'b0;
        expect_status(status(FR, 1'b1, 1'b1));
        wb(1'b0, pll_mode_pkg::IRQ_STATUS_OFFSET, 32'h0000_0000);
        check(rd, 32'h0000_0005);
        irq_is(1'b1);
        wb(1'b1, pll_mode_pkg::IRQ_MASK_OFFSET, 32'h0000_0000);
        irq_is(1'b0);
        $display("interrupt test done");
        // Reset in mid-run with a reference present and lock enabled
        @(posedge core_clk);
        lockModeN <= 1'b1;
        run <= 1'b1;
        nrst <= 1'b0;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        wb(1'b0, pll_mode_pkg::CTRL_OFFSET, 32'h0000_0000);
        check(rd, pll_mode_pkg::CTRL_RESET);
        expect_status(status(FR, 1'b0, 1'b1));
        $display("reset test done");
        results();
    end
endmodule : pll_mode_control_tb
`default_nettype wire

/* verification/pll_mode_monitor.sv */
// Purpose: Port-level checks of the genlock mode controller
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound to every controller instance
`timescale 1ns/10ps
`default_nettype none
module pll_mode_monitor (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic freerunSwitchClose,
    input wire logic loopFilterOe,
    input wire logic pdEnable,
    input wire logic refLoss,
    input wire logic lockMissing,
    input wire logic frameAlignPulse
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // Filter pin ownership follows the operating state
    a_freerun_bias: assert property (
        freerunSwitchClose |-> !loopFilterOe && !pdEnable)
        else $error("filter driven during free run");
    a_genlock_drive: assert property (
        loopFilterOe |-> pdEnable && !freerunSwitchClose)
        else $error("filter driven outside genlock");
    // Loss must release the filter within one cycle, and keep it released
    a_loss_hiz: assert property (
        $rose(refLoss) |-> ##[0:1] !loopFilterOe)
        else $error("filter still driven after loss");
    a_loss_exit: assert property (
        refLoss [*2] |-> !pdEnable)
        else $error("phase detector on without reference");
    // Holdover leaves at the first returning sync edge
    a_regain_lock: assert property (
        $fell(refLoss) && !freerunSwitchClose |-> ##[0:1] pdEnable)
        else $error("holdover not left on regain");
    a_lock_flag: assert property (
        !pdEnable |-> lockMissing)
        else $error("lock reported outside genlock");
    a_reset_start: assert property (
        $rose(nrst) |-> freerunSwitchClose && refLoss)
        else $error("not in free run after reset");
    // Alignment is a single pulse and only while locking
    a_align_pulse: assert property (
        frameAlignPulse |=> !frameAlignPulse)
        else $error("alignment pulse too long");
    a_align_genlock: assert property (
        frameAlignPulse |-> pdEnable || $past(pdEnable))
        else $error("alignment outside genlock");
endmodule : pll_mode_monitor
bind pll_mode_control pll_mode_monitor u_pll_mode_monitor (
    .core_clk, .nrst, .freerunSwitchClose, .loopFilterOe,
    .pdEnable, .refLoss, .lockMissing, .frameAlignPulse);
`default_nettype wire

/* verification/sync_source.sv */
// Purpose: Reference sync source on the far side of the controller
// Assumes: One hsync every period+1 cycles while running
// Notes: Lines sit low when gated off, as with a pull-down
`timescale 1ns/10ps
`default_nettype none
module sync_source (
    input wire logic core_clk,
    input wire logic run,
    input wire logic [7:0] period,
    output logic hsyncIn,
    output logic vsyncIn,
    output logic pllLocked
);
    logic [7:0] cnt = 8'h00;
    logic [3:0] lines = 4'h0;
    // Line and frame counters; a frame is sixteen lines
    always_ff @(posedge core_clk) begin
        cnt <= (!run || cnt >= period) ? 8'h00 : cnt + 8'h01;
        lines <= (cnt == period) ? lines + 4'h1 : lines;
    end
    // Loop reports lock only while a reference is applied
    assign hsyncIn = run && cnt < 8'h04;
    // Vsync trails hsync by a cycle, so hsync is high at its edge
    assign vsyncIn = run && lines == 4'hF && cnt >= 8'h01 && cnt < 8'h08;
    assign pllLocked = run;
endmodule : sync_source
`default_nettype wire
